// [inc/rbms_pkg.sv]
// Constants, encodings and register map of the rod bank motion supervisor.
// Assumes a single 20 MHz plant clock shared by every user of this package.
package rbms_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ       = 20_000_000;
	localparam int STEP_SEQ_MS  = 780;
	localparam int STEP_SEQ_CYC = STEP_SEQ_MS * (CLK_HZ / 1000);
	localparam int SEC_PER_MIN  = 60;
	// Rate accumulator wraps once per step at the demanded steps/minute
	localparam int STEP_ACC_LIM = SEC_PER_MIN * CLK_HZ;

	// ---------------------------------------------------------------
	// Speeds, travel and geometry
	// ---------------------------------------------------------------
	localparam logic [6:0] SPM_MAX   = 7'h48;
	localparam logic [6:0] SPM_MIN   = 7'h08;
	localparam logic [6:0] RATE_RST  = 7'h30;
	localparam logic [7:0] TRAVEL    = 8'he4;
	localparam logic [7:0] OVL_LIMIT = 8'h72;
	localparam logic [7:0] OVL_RST   = 8'h64;
	localparam int         NGRP      = 8;
	localparam int         NCAB      = 2;
	localparam int         NDET      = 5;
	localparam int         DET_MUX   = 3;
	localparam int         SYW       = 17 + NCAB * NDET;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ADR_OVL  = 8'h00;
	localparam logic [7:0] ADR_RATE = 8'h04;
	localparam logic [7:0] ADR_STAT = 8'h08;
	localparam logic [7:0] ADR_POS  = 8'h10;
	localparam logic [7:0] ADR_END  = 8'h30;
	localparam int         ST_REJ   = 8;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	// ---------------------------------------------------------------
	// Encodings
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_AUTO = 2'b00,
		MODE_MAN  = 2'b01,
		MODE_BANK = 2'b10
	} rbms_mode_type;

	typedef enum logic [1:0] {
		DIR_HOLD = 2'b00,
		DIR_OUT  = 2'b01,
		DIR_IN   = 2'b10
	} rbms_dir_type;

	typedef enum logic [2:0] {
		CY_IDLE = 3'b000,
		CY_GRIP = 3'b001,
		CY_LIFT = 3'b010,
		CY_XFER = 3'b011,
		CY_RELS = 3'b100
	} rbms_cy_type;

endpackage : rbms_pkg

// [rtl/rbms_cycler.sv]
// Slave cycler: runs one fixed-length coil sequence per start pulse.
// Assumes start_i only while busy_o is low; abort_i ends a step at once.
`timescale 1ns/1ps
module rbms_cycler import rbms_pkg::*; #(
	parameter int SEQ_CYC = STEP_SEQ_CYC
) (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic start_i,
	input  wire logic out_i,
	input  wire logic abort_i,
	output logic      busy_o,
	output logic      done_o,
	output logic      lift_o,
	output logic      mov_o,
	output logic      stat_o
);

	localparam int          QTR    = (SEQ_CYC / 4 > 0) ? SEQ_CYC / 4 : 1;
	localparam logic [23:0] QTR_M1 = 24'(QTR - 1);

	rbms_cy_type st;
	rbms_cy_type next_st;
	logic [23:0] cnt;
	logic        out_q;

	always_comb begin
		case (st)
			CY_GRIP: next_st = CY_LIFT;
			CY_LIFT: next_st = CY_XFER;
			CY_XFER: next_st = CY_RELS;
			default: next_st = CY_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st    <= CY_IDLE;
			cnt   <= 24'h000000;
			out_q <= 1'b0;
		end else if (abort_i) begin
			st  <= CY_IDLE;
			cnt <= 24'h000000;
		end else if (st == CY_IDLE) begin
			if (start_i) begin
				st    <= CY_GRIP;
				out_q <= out_i;
			end
		end else if (cnt == QTR_M1) begin
			cnt <= 24'h000000;
			st  <= next_st;
		end else begin
			cnt <= cnt + 24'h000001;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			done_o <= 1'b0;
		end else begin
			done_o <= (st == CY_RELS) && (cnt == QTR_M1) && !abort_i;
		end
	end

	// Insertion raises the latch while gripping, withdrawal after
	assign busy_o = (st != CY_IDLE);
	assign lift_o = out_q ? (st == CY_LIFT) : (st == CY_GRIP);
	assign mov_o  = (st == CY_GRIP) || (st == CY_LIFT) || (st == CY_XFER);
	assign stat_o = (st != CY_LIFT);

endmodule : rbms_cycler

// [rtl/rbms_supervisor.sv]
// Rod bank motion supervisor: command buffer, bank sequencing, rate
// limit, urgent alarm handling and coil drive, with an AXI4-Lite slave.
// Assumes all lever, demand and detector pins are asynchronous.
//
// Summary of operation
// - lever acts only with selector in manual or individual bank.
// - in automatic, only automatic demands move rods; lever ignored.
// - step needs selector state and non-hold lever (automatic demand in automatic) together.
// - overlap and bank order enforced in automatic and manual.
// - every motion command is latched in a buffer before stepping.
// - while moving, out-of-sequence commands are refused, not stored.
// - on command change, running step finishes, then motion stops.
// - multiplexing failure detector stops withdrawal and insertion.
// - input module fault raises the logic urgent alarm.
// - any cabinet urgent alarm halts all sequenced motion.
// - on cabinet alarm lift off, grippers at reduced current.
// - cabinet alarm lights panel lamp and plant annunciator.
// - cabinet alarm is OR of five failure detectors.
// - stepping rate never exceeds 72 steps per minute.
// - each step is a fixed 780 ms sequence, paced by pulser.
// - one group at a time per cabinet gets coil drive.
// - automatic speed spans 8 to 72 steps/min by error size.
// - groups of a bank alternate, never more than one step apart.
// - withdraw A to D, insert D to A, next at overlap point.
// - overlap from 0 up to under half travel, one-step exact.
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module rbms_supervisor import rbms_pkg::*; #(
	parameter int SEQ_CYC = STEP_SEQ_CYC,
	parameter int ACC_LIM = STEP_ACC_LIM
) (
	input  wire logic                   clk_i,
	input  wire logic                   rstn_i,
	input  wire logic [7:0]             s_axi_awaddr_i,
	input  wire logic                   s_axi_awvalid_i,
	output logic                        s_axi_awready_o,
	input  wire logic [31:0]            s_axi_wdata_i,
	input  wire logic [3:0]             s_axi_wstrb_i,
	input  wire logic                   s_axi_wvalid_i,
	output logic                        s_axi_wready_o,
	output logic [1:0]                  s_axi_bresp_o,
	output logic                        s_axi_bvalid_o,
	input  wire logic                   s_axi_bready_i,
	input  wire logic [7:0]             s_axi_araddr_i,
	input  wire logic                   s_axi_arvalid_i,
	output logic                        s_axi_arready_o,
	output logic [31:0]                 s_axi_rdata_o,
	output logic [1:0]                  s_axi_rresp_o,
	output logic                        s_axi_rvalid_o,
	input  wire logic                   s_axi_rready_i,
	input  wire logic                   lever_in_i,
	input  wire logic                   lever_out_i,
	input  wire logic [2:0]             bank_sel_i,
	input  wire logic                   auto_in_i,
	input  wire logic                   auto_out_i,
	input  wire logic [7:0]             auto_err_i,
	input  wire logic                   io_fault_i,
	input  wire logic                   op_reset_i,
	input  wire logic [NCAB*NDET-1:0]   cab_det_i,
	output logic                        step_o,
	output logic [2:0]                  step_group_o,
	output logic                        step_dir_o,
	output logic [NGRP-1:0]             lift_o,
	output logic [NGRP-1:0]             mov_o,
	output logic [NGRP-1:0]             stat_o,
	output logic [NCAB-1:0]             reduced_o,
	output logic [NCAB-1:0]             cab_lamp_o,
	output logic                        annunc_o,
	output logic                        logic_urgent_o
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [SYW-1:0]       sy1;
	logic [SYW-1:0]       sy2;
	logic                 lev_in;
	logic                 lev_out;
	logic [2:0]           sel;
	logic                 a_in;
	logic                 a_out;
	logic [7:0]           a_err;
	logic                 io_flt;
	logic                 op_rst;
	logic [NCAB*NDET-1:0] det;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sy1 <= '0;
			sy2 <= '0;
		end else begin
			sy1 <= {lever_in_i, lever_out_i, bank_sel_i, auto_in_i,
				auto_out_i, auto_err_i, io_fault_i, op_reset_i, cab_det_i};
			sy2 <= sy1;
		end
	end

	assign {lev_in, lev_out, sel, a_in, a_out, a_err, io_flt, op_rst,
		det} = sy2;

	// ---------------------------------------------------------------
	// Command forming
	// ---------------------------------------------------------------
	rbms_mode_type in_mode;
	rbms_dir_type  in_dir;
	rbms_dir_type  lev_dir;
	rbms_dir_type  auto_dir;

	assign lev_dir  = (lev_out && !lev_in) ? DIR_OUT :
		(lev_in && !lev_out) ? DIR_IN : DIR_HOLD;
	assign auto_dir = (a_out && !a_in) ? DIR_OUT :
		(a_in && !a_out) ? DIR_IN : DIR_HOLD;
	assign in_mode  = sel[2] ? MODE_BANK : sel[0] ? MODE_MAN : MODE_AUTO;
	assign in_dir   = (in_mode == MODE_AUTO) ? auto_dir : lev_dir;

	// ---------------------------------------------------------------
	// Urgent alarms
	// ---------------------------------------------------------------
	logic [NCAB-1:0] cab_urg;
	logic [NCAB-1:0] pc_lat;
	logic            logic_lat;
	logic            mux_stop;
	logic            halt;

	genvar c;
	generate
		for (c = 0; c < NCAB; c++) begin : g_cab
			assign cab_urg[c] = |det[c*NDET +: NDET];
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					pc_lat[c] <= 1'b0;
				end else if (cab_urg[c]) begin
					pc_lat[c] <= 1'b1;
				end else if (op_rst) begin
					pc_lat[c] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			logic_lat <= 1'b0;
		end else if (io_flt) begin
			logic_lat <= 1'b1;
		end else if (op_rst) begin
			logic_lat <= 1'b0;
		end
	end

	always_comb begin
		mux_stop = 1'b0;
		for (int i = 0; i < NCAB; i++) begin
			mux_stop = mux_stop | det[i*NDET + DET_MUX];
		end
	end

	assign halt = (|pc_lat) | (|cab_urg) | logic_lat | io_flt | mux_stop;

	// ---------------------------------------------------------------
	// Command buffer
	// ---------------------------------------------------------------
	rbms_mode_type cmd_mode;
	rbms_dir_type  cmd_dir;
	logic [1:0]    cmd_bank;
	logic          armed;
	logic          stop_pend;
	logic          reject_set;
	logic          moving;
	logic          in_diff;
	logic          cy_busy;

	assign moving  = (cmd_dir != DIR_HOLD);
	assign in_diff = {in_mode, in_dir, sel[1:0]} !=
		{cmd_mode, cmd_dir, cmd_bank};

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cmd_mode   <= MODE_AUTO;
			cmd_dir    <= DIR_HOLD;
			cmd_bank   <= 2'h0;
			armed      <= 1'b0;
			stop_pend  <= 1'b0;
			reject_set <= 1'b0;
		end else begin
			reject_set <= 1'b0;
			if (in_dir == DIR_HOLD) begin
				armed <= 1'b1;
			end
			if (halt) begin
				cmd_dir   <= DIR_HOLD;
				stop_pend <= 1'b0;
			end else if (stop_pend) begin
				if (!cy_busy) begin
					cmd_dir   <= DIR_HOLD;
					stop_pend <= 1'b0;
				end
			end else if (armed && in_diff) begin
				if (!moving) begin
					cmd_mode <= in_mode;
					cmd_dir  <= in_dir;
					cmd_bank <= sel[1:0];
				end else if (in_dir == DIR_HOLD) begin
					stop_pend <= 1'b1;
				end else begin
					reject_set <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Bank sequencing
	// ---------------------------------------------------------------
	logic [7:0] pos [NGRP];
	logic [7:0] ovl;
	logic [7:0] thr;
	logic [1:0] b_first;
	logic [1:0] b_sec;
	logic       pair;
	logic       up;
	logic       alt;
	logic [2:0] ga;
	logic [2:0] gb;
	logic       can_a;
	logic       can_b;
	logic [2:0] g_pick;
	logic       g_ok;

	function automatic logic lag(input logic [7:0] p0,
		input logic [7:0] p1, input logic dir_up);
		lag = dir_up ? (p1 < p0) : (p1 > p0);
	endfunction : lag

	function automatic logic room(input logic [7:0] p,
		input logic dir_up);
		room = dir_up ? (p != TRAVEL) : (p != 8'h00);
	endfunction : room

	assign up  = (cmd_dir == DIR_OUT);
	assign thr = TRAVEL - ovl;

	always_comb begin
		b_first = 2'h0;
		b_sec   = 2'h0;
		pair    = 1'b0;
		if (cmd_mode == MODE_BANK) begin
			b_first = cmd_bank;
		end else if (up) begin
			for (int b = 3; b >= 0; b--) begin
				if (pos[2*b] != TRAVEL || pos[2*b+1] != TRAVEL) begin
					b_first = 2'(b);
				end
			end
			pair  = (b_first != 2'h3) && (pos[{b_first, 1'b0}] >= thr);
			b_sec = b_first + 2'h1;
		end else begin
			for (int b = 0; b < 4; b++) begin
				if (pos[2*b] != 8'h00 || pos[2*b+1] != 8'h00) begin
					b_first = 2'(b);
				end
			end
			pair  = (b_first != 2'h0) && (pos[{b_first, 1'b0}] <= ovl);
			b_sec = b_first - 2'h1;
		end
	end

	assign ga     = {b_first, lag(pos[{b_first, 1'b0}],
		pos[{b_first, 1'b1}], up)};
	assign gb     = {b_sec, lag(pos[{b_sec, 1'b0}],
		pos[{b_sec, 1'b1}], up)};
	assign can_a  = room(pos[ga], up);
	assign can_b  = pair && room(pos[gb], up);
	assign g_pick = ((alt && can_b) || !can_a) ? gb : ga;
	assign g_ok   = can_a || can_b;

	// ---------------------------------------------------------------
	// Rate pacing and stepping
	// ---------------------------------------------------------------
	logic [6:0]  man_rate;
	logic [14:0] err_prod;
	logic [6:0]  spm_raw;
	logic [6:0]  spm;
	logic [31:0] acc;
	logic        fire;
	logic        cy_done;
	logic        cy_lift;
	logic        cy_mov;
	logic        cy_stat;

	assign err_prod = {7'h00, a_err} * 15'h0041;
	assign spm_raw  = (cmd_mode == MODE_AUTO) ?
		SPM_MIN + err_prod[14:8] : man_rate;
	assign spm      = (spm_raw > SPM_MAX) ? SPM_MAX : spm_raw;

	// Never in the done cycle: positions settle one edge later
	// next step waits both pulser and sequence
	assign fire = moving && !halt && !stop_pend && !cy_busy && !cy_done &&
		g_ok && (acc >= 32'(ACC_LIM));

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			acc <= 32'h00000000;
		end else if (!moving || halt) begin
			acc <= 32'h00000000;
		end else if (fire) begin
			acc <= acc - 32'(ACC_LIM);
		end else if (acc < 32'(ACC_LIM)) begin
			acc <= acc + {25'h0000000, spm};
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			step_o       <= 1'b0;
			step_group_o <= 3'h0;
			step_dir_o   <= 1'b0;
			alt          <= 1'b0;
		end else begin
			step_o <= fire;
			if (fire) begin
				step_group_o <= g_pick;
				step_dir_o   <= up;
				alt          <= ~alt;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < NGRP; i++) begin
				pos[i] <= 8'h00;
			end
		end else if (cy_done) begin
			pos[step_group_o] <= step_dir_o ?
				pos[step_group_o] + 8'h01 : pos[step_group_o] - 8'h01;
		end
	end

	rbms_cycler #(
		.SEQ_CYC (SEQ_CYC)
	) u_cycler (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.start_i (step_o),
		.out_i   (step_dir_o),
		.abort_i (halt),
		.busy_o  (cy_busy),
		.done_o  (cy_done),
		.lift_o  (cy_lift),
		.mov_o   (cy_mov),
		.stat_o  (cy_stat)
	);

	// ---------------------------------------------------------------
	// Coil drive
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NGRP; g++) begin : g_coil
			logic here;
			logic urg;
			assign here = (step_group_o == 3'(g));
			assign urg  = pc_lat[g/4] | cab_urg[g/4];
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					lift_o[g] <= 1'b0;
					mov_o[g]  <= 1'b0;
					stat_o[g] <= 1'b1;
				end else if (urg) begin
					lift_o[g] <= 1'b0;
					mov_o[g]  <= here;
					stat_o[g] <= 1'b1;
				end else begin
					lift_o[g] <= here && cy_busy && cy_lift;
					mov_o[g]  <= here && cy_busy && cy_mov;
					stat_o[g] <= !(here && cy_busy) || cy_stat;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reduced_o      <= '0;
			cab_lamp_o     <= '0;
			annunc_o       <= 1'b0;
			logic_urgent_o <= 1'b0;
		end else begin
			reduced_o      <= pc_lat | cab_urg;
			cab_lamp_o     <= pc_lat | cab_urg;
			annunc_o       <= (|pc_lat) | (|cab_urg);
			logic_urgent_o <= logic_lat | io_flt;
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite slave
	// ---------------------------------------------------------------
	logic        aw_full;
	logic        w_full;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_go;
	logic        rej;
	logic        rej_clr;
	logic [31:0] rd_word;
	logic        rd_err;
	logic [2:0]  pidx;

	assign s_axi_awready_o = !aw_full && !s_axi_bvalid_o;
	assign s_axi_wready_o  = !w_full && !s_axi_bvalid_o;
	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign wr_go   = aw_full && w_full;
	assign rej_clr = wr_go && (aw_addr == ADR_STAT) && w_strb[1] &&
		w_data[ST_REJ];

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			aw_full        <= 1'b0;
			w_full         <= 1'b0;
			aw_addr        <= 8'h00;
			w_data         <= 32'h00000000;
			w_strb         <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= RESP_OK;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (wr_go) begin
				aw_full        <= 1'b0;
				w_full         <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= (aw_addr == ADR_OVL ||
					aw_addr == ADR_RATE || aw_addr == ADR_STAT) ?
					RESP_OK : RESP_ERR;
			end else if (s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ovl      <= OVL_RST;
			man_rate <= RATE_RST;
		end else if (wr_go && w_strb[0]) begin
			if (aw_addr == ADR_OVL) begin
				ovl <= (w_data[7:0] >= OVL_LIMIT) ?
					OVL_LIMIT - 8'h01 : w_data[7:0];
			end
			if (aw_addr == ADR_RATE) begin
				man_rate <= w_data[6:0];
			end
		end
	end

	// Set wins over a same-cycle clear
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rej <= 1'b0;
		end else if (reject_set) begin
			rej <= 1'b1;
		end else if (rej_clr) begin
			rej <= 1'b0;
		end
	end

	assign pidx = 3'(s_axi_araddr_i[5:2] - 4'h4);

	always_comb begin
		rd_word = 32'h00000000;
		rd_err  = 1'b0;
		case (s_axi_araddr_i)
			ADR_OVL:  rd_word = {24'h000000, ovl};
			ADR_RATE: rd_word = {25'h0000000, man_rate};
			ADR_STAT: rd_word = {19'h00000, armed, logic_lat, pc_lat, rej,
				stop_pend, cy_busy, cmd_bank, cmd_mode, cmd_dir};
			default: begin
				if (s_axi_araddr_i >= ADR_POS && s_axi_araddr_i < ADR_END) begin
					rd_word = {24'h000000, pos[pidx]};
				end else begin
					rd_err = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h00000000;
			s_axi_rresp_o  <= RESP_OK;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o  <= rd_word;
			s_axi_rresp_o  <= rd_err ? RESP_ERR : RESP_OK;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

endmodule : rbms_supervisor

// [verif/rbms_cab_model.sv]
// Far-side model of the two power cabinets and their detectors.
// Assumes the bench names the detector to trip; lift drive is watched.
`timescale 1ns/1ps
module rbms_cab_model import rbms_pkg::*; (
	input  wire logic                 clk_i,
	input  wire logic                 rstn_i,
	input  wire logic [NCAB*NDET-1:0] trip_i,
	input  wire logic [NGRP-1:0]      lift_i,
	output logic      [NCAB*NDET-1:0] det_o
);
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			det_o <= '0;
		else begin
			det_o <= trip_i;
			for (int c = 0; c < NCAB; c++)
				if (!$onehot0(lift_i[c*4 +: 4]))
					det_o[c*NDET+DET_MUX] <= 1'h1;
		end
	end
endmodule : rbms_cab_model

// [verif/rbms_supervisor_assertions.sv]
// Concurrent checks on the top ports of the rod bank motion supervisor.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module rbms_sup_chk import rbms_pkg::*; #(
	parameter int SEQ_CYC = STEP_SEQ_CYC,
	parameter int ACC_LIM = STEP_ACC_LIM
) (
	input wire logic                 clk_i,
	input wire logic                 rstn_i,
	input wire logic                 io_fault_i,
	input wire logic                 op_reset_i,
	input wire logic [NCAB*NDET-1:0] cab_det_i,
	input wire logic                 step_o,
	input wire logic [NGRP-1:0]      lift_o,
	input wire logic [NGRP-1:0]      mov_o,
	input wire logic [NCAB-1:0]      reduced_o,
	input wire logic [NCAB-1:0]      cab_lamp_o,
	input wire logic                 annunc_o,
	input wire logic                 logic_urgent_o
);
	logic [3:0] opr_hist;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	// Operator reset seen within the last four edges
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			opr_hist <= 4'h0;
		else
			opr_hist <= {opr_hist[2:0], op_reset_i};
	end

	// ----
	// Assertions
	// ----
	a_step_single: assert property (step_o |=> !step_o [*8])
		else $error("step too soon");
	a_one_group: assert property (
		$onehot0(lift_o[3:0]) && $onehot0(lift_o[7:4]))
		else $error("two groups lifted");
	a_halt_step: assert property (annunc_o |-> !step_o)
		else $error("step during alarm");
	a_lamp_annunc: assert property (|cab_lamp_o |-> annunc_o)
		else $error("lamp without annunciator");
	a_alarm_coil: assert property (cab_lamp_o[0] |-> reduced_o[0] &&
		lift_o[3:0] == 4'h0 && $onehot0(mov_o[3:0]))
		else $error("coils not safe in alarm");
	a_det_lamp: assert property (
		(|cab_det_i[4:0]) [*4] |-> ##[0:1] cab_lamp_o[0])
		else $error("detector without lamp");
	a_io_alarm: assert property (
		io_fault_i [*4] |-> ##[0:1] logic_urgent_o)
		else $error("io fault not raised");
	a_lamp_latch: assert property ($fell(cab_lamp_o[0]) |-> |opr_hist)
		else $error("lamp cleared without reset");

	cover property (step_o);
	cover property ($rose(cab_lamp_o[1]));
	cover property ($rose(logic_urgent_o));
endmodule : rbms_sup_chk

bind rbms_supervisor rbms_sup_chk #(.SEQ_CYC(SEQ_CYC), .ACC_LIM(ACC_LIM))
	chk_inst (.*);

// [verif/testbench.sv]
// Self-checking bench of the rod bank motion supervisor.
// Assumes short step parameters; the cabinet model drives the detectors.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin \
	check_count++; \
	if ((s) !== (e)) begin \
		err_count++; \
		$display("[ERR] %s exp %0h got %0h", nm, e, s); \
	end \
end
module testbench import rbms_pkg::*;;
	localparam int ACC = 7200;
	logic        clk_i = 1'h0, rstn_i = 1'h0;
	logic [7:0]  s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
	logic [7:0]  auto_err_i = 8'h0, lift_o, mov_o, stat_o;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, d, d2;
	logic [3:0]  s_axi_wstrb_i = 4'hf;
	logic        s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0;
	logic        s_axi_arvalid_i = 1'h0, s_axi_bready_i = 1'h0;
	logic        s_axi_rready_i = 1'h0, lever_in_i = 1'h0;
	logic        lever_out_i = 1'h0, auto_in_i = 1'h0, auto_out_i = 1'h0;
	logic        io_fault_i = 1'h0, op_reset_i = 1'h0;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic        s_axi_arready_o, s_axi_rvalid_o, step_o, step_dir_o;
	logic        annunc_o, logic_urgent_o, ha, hw, hb;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, reduced_o, cab_lamp_o, r;
	logic [2:0]  bank_sel_i = 3'h0, step_group_o;
	logic [9:0]  cab_det_i, trip = 10'h0;
	logic [7:0]  ov [4] = '{8'h71, 8'h72, 8'h00, 8'hff};
	int          err_count = 0, check_count = 0, nstep = 0, t, n;

	rbms_supervisor #(.SEQ_CYC(40), .ACC_LIM(ACC)) rbms_supervisor_inst (.*);
	rbms_cab_model rbms_cab_model_inst (.clk_i(clk_i), .rstn_i(rstn_i),
		.trip_i(trip), .lift_i(lift_o), .det_o(cab_det_i));

	initial forever #25 clk_i = ~clk_i;
	always @(negedge clk_i) nstep += (step_o === 1'h1);

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask : cyc

	task automatic wstep(output int c);
		c = 0;
		do begin
			@(negedge clk_i);
			c++;
		end while (step_o !== 1'h1 && c < 3000);
		if (c >= 3000)
			err_count++;
		@(posedge clk_i);
	endtask : wstep

	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= v;
		s_axi_awvalid_i <= 1'h1;
		s_axi_wvalid_i <= 1'h1;
		s_axi_bready_i <= 1'h1;
		do begin
			@(negedge clk_i);
			ha = s_axi_awready_o & s_axi_awvalid_i;
			hw = s_axi_wready_o & s_axi_wvalid_i;
			hb = s_axi_bvalid_o;
			r = s_axi_bresp_o;
			@(posedge clk_i);
			if (ha)
				s_axi_awvalid_i <= 1'h0;
			if (hw)
				s_axi_wvalid_i <= 1'h0;
		end while (!hb);
		s_axi_bready_i <= 1'h0;
	endtask : axw

	task automatic axr(input logic [7:0] a);
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'h1;
		s_axi_rready_i <= 1'h1;
		do begin
			@(negedge clk_i);
			ha = s_axi_arready_o & s_axi_arvalid_i;
			hb = s_axi_rvalid_o;
			d = s_axi_rdata_o;
			r = s_axi_rresp_o;
			@(posedge clk_i);
			if (ha)
				s_axi_arvalid_i <= 1'h0;
		end while (!hb);
		s_axi_rready_i <= 1'h0;
	endtask : axr

	task automatic pulse_opr;
		@(posedge clk_i);
		op_reset_i <= 1'h1;
		cyc(4);
		op_reset_i <= 1'h0;
		cyc(4);
		@(negedge clk_i);
	endtask : pulse_opr

	function automatic logic [31:0] exp_ovl(input logic [7:0] v);
		return {24'h0, ((v >= OVL_LIMIT) ? OVL_LIMIT - 8'h1 : v)};
	endfunction : exp_ovl

	task automatic tend(input string s);
		$display("test %s done", s);
	endtask : tend

	task automatic final_report;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	initial begin
		cyc(20000);
		err_count++;
		final_report();
	end

	// ----
	// Main sequence
	// ----
	initial begin
		void'($urandom(32'h9597));
		ov[2] = 8'($urandom);
		cyc(5);
		rstn_i <= 1'h1;
		axr(ADR_OVL);
		`CHK("ovl_rst", {24'h0, OVL_RST}, d)
		axr(ADR_END);
		`CHK("unmapped", RESP_ERR, r)
		axw(ADR_POS, 32'h5);
		`CHK("ro_pos", RESP_ERR, r)
		foreach (ov[i]) begin
			axw(ADR_OVL, {24'h0, ov[i]});
			axr(ADR_OVL);
			`CHK("ovl", exp_ovl(ov[i]), d)
		end
		axw(ADR_RATE, 32'h7f);
		tend("regs");
		lever_out_i <= 1'h1;
		cyc(300);
		`CHK("auto_lever", 0, nstep)
		auto_err_i <= 8'hff;
		auto_out_i <= 1'h1;
		wstep(t);
		`CHK("auto_dir", 1'h1, step_dir_o)
		auto_out_i <= 1'h0;
		lever_out_i <= 1'h0;
		repeat (8) begin
			bank_sel_i <= 3'($urandom);
			auto_err_i <= 8'($urandom);
			cyc(40);
		end
		`CHK("hold_sel", 1, nstep)
		tend("auto");
		bank_sel_i <= 3'h1;
		lever_out_i <= 1'h1;
		wstep(t);
		`CHK("grp_lag", 3'h1, step_group_o)
		`CHK("man_dir", 1'h1, step_dir_o)
		wstep(t);
		`CHK("alt", 3'h0, step_group_o)
		`CHK("rate", 1'h1, t >= ACC / 72 - 2)
		lever_out_i <= 1'h0;
		lever_in_i <= 1'h1;
		cyc(8);
		lever_in_i <= 1'h0;
		lever_out_i <= 1'h1;
		axr(ADR_STAT);
		`CHK("reject", 3'h5, {d[ST_REJ], d[1:0]})
		wstep(t);
		lever_out_i <= 1'h0;
		n = nstep;
		cyc(300);
		`CHK("stop", n, nstep)
		axr(ADR_POS);
		d2 = d;
		axr(ADR_POS + 8'h4);
		`CHK("pos", n, d + d2)
		lever_in_i <= 1'h1;
		wstep(t);
		`CHK("in_dir", 1'h0, step_dir_o)
		lever_in_i <= 1'h0;
		tend("manual");
		for (int k = 0; k < NDET; k++) begin
			@(posedge clk_i);
			trip <= 10'h21 << k;
			cyc(6);
			trip <= 10'h0;
			cyc(6);
			@(negedge clk_i);
			`CHK("lamp", 2'h3, cab_lamp_o)
			`CHK("annunc", 1'h1, annunc_o)
			pulse_opr();
			`CHK("clear", 2'h0, cab_lamp_o)
		end
		@(posedge clk_i);
		lever_out_i <= 1'h1;
		wstep(t);
		trip <= 10'h08;
		cyc(6);
		@(negedge clk_i);
		`CHK("lift_off", 4'h0, lift_o[3:0])
		`CHK("reduced", 1'h1, reduced_o[0])
		`CHK("stat", 4'hf, stat_o[3:0])
		n = nstep;
		cyc(300);
		`CHK("mux_halt", n, nstep)
		tend("alarm");
		io_fault_i <= 1'h1;
		cyc(6);
		@(negedge clk_i);
		`CHK("logic_urg", 1'h1, logic_urgent_o)
		tend("fault");
		final_report();
	end
endmodule : testbench
